/* File: rtl/curve_map.v */
// three-point curve mapper: analog samples to signed frequency commands
// assumes samples arrive on CLK from the sampling converter, one-cycle valids
// How it works
// - the three positive input points are unsigned 16-bit hundredths of a volt.
// - every percent point is a signed 16-bit value in hundredths of a percent.
// - a positive percent scales to max frequency and commands forward rotation.
// - output is interpolated between adjacent points whatever the percent points are.
// - a positive sample below the lowest point gives zero percent.
// - a sample equal to the lowest point gives zero, just above it the low percent.
// - the negative points are signed and used only in the bipolar range mode.
// - a negative percent scales to max frequency and commands reverse rotation.
// - negative percent points are free and interpolated linearly.
// - a negative sample from zero down to the near-zero point gives zero percent.
// - there is no hysteresis at the cut-off point.
// - the second input gives zero at or below its lowest point, then its low percent.
// - the curve select picks normal, first, second or both curves.
// - range select three enables the negative half of the first input curve.
//
// Strobed register access is this design's own decision.
module curve_map (
    input wire CLK,
    input wire SYS_RST,
    input wire [15:0] ADDR,
    input wire [15:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [15:0] RDATA,
    input wire [15:0] FIRST_SAMPLE,
    input wire FIRST_VALID,
    input wire [15:0] SECOND_SAMPLE,
    input wire SECOND_VALID,
    output reg [15:0] FIRST_PERCENT,
    output reg [15:0] FIRST_FREQ,
    output reg FIRST_REVERSE,
    output reg FIRST_DONE,
    output reg FIRST_CURVE_ON,
    output reg [15:0] SECOND_PERCENT,
    output reg [15:0] SECOND_FREQ,
    output reg SECOND_REVERSE,
    output reg SECOND_DONE,
    output reg SECOND_CURVE_ON,
    output wire BUSY
);
`include "curve_regs.vh"

localparam ST_IDLE = 3'h0;
localparam ST_PICK = 3'h1;
localparam ST_DIV1 = 3'h2;
localparam ST_SCALE = 3'h3;
localparam ST_DIV2 = 3'h4;
localparam ST_FINISH = 3'h5;

////////////////////////////////////////////////////////////////////////////////
// register file

// address to storage index, IDX_NONE where nothing is mapped
function [4:0] decode;
    input [15:0] a;
    begin
        case (a)
            `ADDR_POS_LO_X: decode = `IDX_POS_LO_X;
            `ADDR_POS_LO_P: decode = `IDX_POS_LO_P;
            `ADDR_POS_MID_X: decode = `IDX_POS_MID_X;
            `ADDR_POS_MID_P: decode = `IDX_POS_MID_P;
            `ADDR_POS_HI_X: decode = `IDX_POS_HI_X;
            `ADDR_POS_HI_P: decode = `IDX_POS_HI_P;
            `ADDR_NEG_NZ_X: decode = `IDX_NEG_NZ_X;
            `ADDR_NEG_NZ_P: decode = `IDX_NEG_NZ_P;
            `ADDR_NEG_MID_X: decode = `IDX_NEG_MID_X;
            `ADDR_NEG_MID_P: decode = `IDX_NEG_MID_P;
            `ADDR_NEG_FAR_X: decode = `IDX_NEG_FAR_X;
            `ADDR_NEG_FAR_P: decode = `IDX_NEG_FAR_P;
            `ADDR_SEC_LO_X: decode = `IDX_SEC_LO_X;
            `ADDR_SEC_LO_P: decode = `IDX_SEC_LO_P;
            `ADDR_SEC_MID_X: decode = `IDX_SEC_MID_X;
            `ADDR_SEC_MID_P: decode = `IDX_SEC_MID_P;
            `ADDR_SEC_HI_X: decode = `IDX_SEC_HI_X;
            `ADDR_SEC_HI_P: decode = `IDX_SEC_HI_P;
            `ADDR_CURVE_SEL: decode = `IDX_CURVE_SEL;
            `ADDR_RANGE_SEL: decode = `IDX_RANGE_SEL;
            `ADDR_MAX_FREQ: decode = `IDX_MAX_FREQ;
            default: decode = `IDX_NONE;
        endcase
    end
endfunction

function [15:0] reset_value;
    input [4:0] i;
    begin
        case (i)
            `IDX_POS_LO_X: reset_value = `RST_POS_LO_X;
            `IDX_POS_LO_P: reset_value = `RST_POS_LO_P;
            `IDX_POS_MID_X: reset_value = `RST_POS_MID_X;
            `IDX_POS_MID_P: reset_value = `RST_POS_MID_P;
            `IDX_POS_HI_X: reset_value = `RST_POS_HI_X;
            `IDX_POS_HI_P: reset_value = `RST_POS_HI_P;
            `IDX_NEG_NZ_X: reset_value = `RST_NEG_NZ_X;
            `IDX_NEG_NZ_P: reset_value = `RST_NEG_NZ_P;
            `IDX_NEG_MID_X: reset_value = `RST_NEG_MID_X;
            `IDX_NEG_MID_P: reset_value = `RST_NEG_MID_P;
            `IDX_NEG_FAR_X: reset_value = `RST_NEG_FAR_X;
            `IDX_NEG_FAR_P: reset_value = `RST_NEG_FAR_P;
            `IDX_SEC_LO_X: reset_value = `RST_SEC_LO_X;
            `IDX_SEC_LO_P: reset_value = `RST_SEC_LO_P;
            `IDX_SEC_MID_X: reset_value = `RST_SEC_MID_X;
            `IDX_SEC_MID_P: reset_value = `RST_SEC_MID_P;
            `IDX_SEC_HI_X: reset_value = `RST_SEC_HI_X;
            `IDX_SEC_HI_P: reset_value = `RST_SEC_HI_P;
            `IDX_CURVE_SEL: reset_value = `RST_CURVE_SEL;
            `IDX_RANGE_SEL: reset_value = `RST_RANGE_SEL;
            default: reset_value = `RST_MAX_FREQ;
        endcase
    end
endfunction

// magnitude of a 17-bit two's complement value
function [16:0] mag17;
    input [16:0] v;
    begin
        mag17 = v[16] ? (~v + 17'h00001) : v;
    end
endfunction

function [16:0] sx;
    input [15:0] v;
    begin
        sx = {v[15], v};
    end
endfunction

reg [15:0] regs_q [0:`NUM_REGS-1];
wire [4:0] hit = decode(ADDR);
wire mapped = hit != `IDX_NONE;

genvar gi;
generate
    for (gi = 0; gi < `NUM_REGS; gi = gi + 1) begin : g_reg
        localparam [4:0] IDX = gi;
        always @(posedge CLK) begin
            if (SYS_RST) begin
                regs_q[gi] <= reset_value(IDX);
            end else if (WR && mapped && hit == IDX) begin
                regs_q[gi] <= WDATA;
            end
        end
    end
endgenerate

reg [2:0] state_q;

always @(posedge CLK) begin
    if (SYS_RST) begin
        RDATA <= 16'h0000;
    end else if (RD) begin
        if (mapped) begin
            RDATA <= regs_q[hit];
        end else if (ADDR == `ADDR_FIRST_RESULT) begin
            RDATA <= FIRST_PERCENT;
        end else if (ADDR == `ADDR_SECOND_RESULT) begin
            RDATA <= SECOND_PERCENT;
        end else if (ADDR == `ADDR_STATUS) begin
            RDATA <= {12'h000, SECOND_REVERSE, FIRST_REVERSE, SECOND_CURVE_ON, BUSY};
        end else begin
            RDATA <= 16'h0000;
        end
    end else begin
        RDATA <= 16'h0000;
    end
end

////////////////////////////////////////////////////////////////////////////////
// mode decode

wire [1:0] curve_sel = regs_q[`IDX_CURVE_SEL][1:0];
wire first_on = (curve_sel == `CURVE_FIRST) || (curve_sel == `CURVE_BOTH);
wire second_on = (curve_sel == `CURVE_SECOND) || (curve_sel == `CURVE_BOTH);
wire bipolar = regs_q[`IDX_RANGE_SEL] == `RANGE_BIPOLAR;

////////////////////////////////////////////////////////////////////////////////
// sample capture; a new sample outranks the take in the same cycle

reg [15:0] s1_q;
reg [15:0] s2_q;
reg pend1_q;
reg pend2_q;
reg src_q;
reg [16:0] x_q;
wire take1 = (state_q == ST_IDLE) && pend1_q;
wire take2 = (state_q == ST_IDLE) && !pend1_q && pend2_q;

always @(posedge CLK) begin
    if (SYS_RST) begin
        s1_q <= 16'h0000;
        s2_q <= 16'h0000;
        pend1_q <= 1'b0;
        pend2_q <= 1'b0;
    end else begin
        if (FIRST_VALID) begin
            s1_q <= FIRST_SAMPLE;
        end
        if (SECOND_VALID) begin
            s2_q <= SECOND_SAMPLE;
        end
        pend1_q <= FIRST_VALID | (pend1_q & ~take1);
        pend2_q <= SECOND_VALID | (pend2_q & ~take2);
    end
end

////////////////////////////////////////////////////////////////////////////////
// segment pick; no hysteresis, each sample is judged on its own

reg cut;
reg hold;
reg [16:0] x0;
reg [16:0] x1;
reg [16:0] p0;
reg [16:0] p1;

wire [16:0] plx = {1'b0, regs_q[`IDX_POS_LO_X]};
wire [16:0] pmx = {1'b0, regs_q[`IDX_POS_MID_X]};
wire [16:0] phx = {1'b0, regs_q[`IDX_POS_HI_X]};
wire [16:0] nzx = sx(regs_q[`IDX_NEG_NZ_X]);
wire [16:0] nmx = sx(regs_q[`IDX_NEG_MID_X]);
wire [16:0] nfx = sx(regs_q[`IDX_NEG_FAR_X]);
wire [16:0] slx = {1'b0, regs_q[`IDX_SEC_LO_X]};
wire [16:0] smx = {1'b0, regs_q[`IDX_SEC_MID_X]};
wire [16:0] shx = {1'b0, regs_q[`IDX_SEC_HI_X]};
wire [16:0] plp = sx(regs_q[`IDX_POS_LO_P]);
wire [16:0] pmp = sx(regs_q[`IDX_POS_MID_P]);
wire [16:0] php = sx(regs_q[`IDX_POS_HI_P]);
wire [16:0] nzp = sx(regs_q[`IDX_NEG_NZ_P]);
wire [16:0] nmp = sx(regs_q[`IDX_NEG_MID_P]);
wire [16:0] nfp = sx(regs_q[`IDX_NEG_FAR_P]);
wire [16:0] slp = sx(regs_q[`IDX_SEC_LO_P]);
wire [16:0] smp = sx(regs_q[`IDX_SEC_MID_P]);
wire [16:0] shp = sx(regs_q[`IDX_SEC_HI_P]);

// the rising order of the input points is trusted, not checked
always @* begin
    cut = 1'b0;
    hold = 1'b0;
    x0 = plx;
    x1 = pmx;
    p0 = plp;
    p1 = pmp;
    if (src_q) begin
        x0 = slx;
        x1 = smx;
        p0 = slp;
        p1 = smp;
        if (!second_on || $signed(x_q) <= $signed(slx)) begin
            cut = 1'b1;
        end else if ($signed(x_q) > $signed(shx)) begin
            hold = 1'b1;
            p0 = shp;
        end else if ($signed(x_q) > $signed(smx)) begin
            x0 = smx;
            x1 = shx;
            p0 = smp;
            p1 = shp;
        end
    end else if (!x_q[16]) begin
        if (!first_on || $signed(x_q) <= $signed(plx)) begin
            cut = 1'b1;
        end else if ($signed(x_q) > $signed(phx)) begin
            hold = 1'b1;
            p0 = php;
        end else if ($signed(x_q) > $signed(pmx)) begin
            x0 = pmx;
            x1 = phx;
            p0 = pmp;
            p1 = php;
        end
    end else begin
        x0 = nzx;
        x1 = nmx;
        p0 = nzp;
        p1 = nmp;
        if (!first_on || !bipolar || $signed(x_q) >= $signed(nzx)) begin
            cut = 1'b1;
        end else if ($signed(x_q) < $signed(nfx)) begin
            hold = 1'b1;
            p0 = nfp;
        end else if ($signed(x_q) < $signed(nmx)) begin
            x0 = nmx;
            x1 = nfx;
            p0 = nmp;
            p1 = nfp;
        end
    end
end

wire [16:0] dx_in = mag17(x_q - x0);
wire [16:0] dx_seg = mag17(x1 - x0);
wire [16:0] dp = p1 - p0;
wire [16:0] dp_mag = mag17(dp);
wire [33:0] seg_prod = dx_in * dp_mag;

////////////////////////////////////////////////////////////////////////////////
// sequencer: interpolate, then scale to max frequency, sharing one divider

reg [16:0] base_q;
reg down_q;
reg [15:0] pct_q;
reg [15:0] freq_q;
reg div_start_q;
reg [31:0] div_num_q;
reg [16:0] div_den_q;
wire [31:0] div_quot;
wire div_done;
// percent magnitude fits 16 bits; the spare top bit is dropped on purpose
wire [16:0] pct_abs = mag17(sx(pct_q));
wire [15:0] pct_mag = pct_abs[15:0];
wire [31:0] scale_prod = pct_mag * regs_q[`IDX_MAX_FREQ];
wire [17:0] interp_sum = down_q ? ({base_q[16], base_q} - {1'b0, div_quot[16:0]})
                                : ({base_q[16], base_q} + {1'b0, div_quot[16:0]});

curve_divider u_div (
    .clk(CLK),
    .rst(SYS_RST),
    .start(div_start_q),
    .dividend(div_num_q),
    .divisor(div_den_q),
    .quotient(div_quot),
    .done(div_done)
);

assign BUSY = (state_q != ST_IDLE) || pend1_q || pend2_q;

always @(posedge CLK) begin
    if (SYS_RST) begin
        state_q <= ST_IDLE;
        src_q <= 1'b0;
        x_q <= 17'h00000;
        base_q <= 17'h00000;
        down_q <= 1'b0;
        pct_q <= 16'h0000;
        freq_q <= 16'h0000;
        div_start_q <= 1'b0;
        div_num_q <= 32'h00000000;
        div_den_q <= 17'h00001;
        FIRST_PERCENT <= 16'h0000;
        FIRST_FREQ <= 16'h0000;
        FIRST_REVERSE <= 1'b0;
        FIRST_DONE <= 1'b0;
        FIRST_CURVE_ON <= 1'b0;
        SECOND_PERCENT <= 16'h0000;
        SECOND_FREQ <= 16'h0000;
        SECOND_REVERSE <= 1'b0;
        SECOND_DONE <= 1'b0;
        SECOND_CURVE_ON <= 1'b0;
    end else begin
        div_start_q <= 1'b0;
        FIRST_DONE <= 1'b0;
        SECOND_DONE <= 1'b0;
        FIRST_CURVE_ON <= first_on;
        SECOND_CURVE_ON <= second_on;
        case (state_q)
            ST_IDLE: begin
                if (take1) begin
                    src_q <= 1'b0;
                    x_q <= sx(s1_q);
                    state_q <= ST_PICK;
                end else if (take2) begin
                    src_q <= 1'b1;
                    x_q <= {1'b0, s2_q};
                    state_q <= ST_PICK;
                end
            end
            ST_PICK: begin
                if (cut) begin
                    pct_q <= 16'h0000;
                    state_q <= ST_SCALE;
                end else if (hold || dx_seg == 17'h00000) begin
                    // a zero-width segment would divide by zero
                    pct_q <= p0[15:0];
                    state_q <= ST_SCALE;
                end else begin
                    base_q <= p0;
                    down_q <= dp[16];
                    div_num_q <= seg_prod[31:0];
                    div_den_q <= dx_seg;
                    div_start_q <= 1'b1;
                    state_q <= ST_DIV1;
                end
            end
            ST_DIV1: begin
                if (div_done) begin
                    pct_q <= interp_sum[15:0];
                    state_q <= ST_SCALE;
                end
            end
            ST_SCALE: begin
                div_num_q <= scale_prod;
                div_den_q <= `PCT_FULL_SCALE;
                div_start_q <= 1'b1;
                state_q <= ST_DIV2;
            end
            ST_DIV2: begin
                if (div_done) begin
                    freq_q <= div_quot[15:0];
                    state_q <= ST_FINISH;
                end
            end
            ST_FINISH: begin
                // sign of the percent gives the direction
                if (src_q) begin
                    SECOND_PERCENT <= pct_q;
                    SECOND_FREQ <= freq_q;
                    SECOND_REVERSE <= pct_q[15];
                    SECOND_DONE <= 1'b1;
                end else begin
                    FIRST_PERCENT <= pct_q;
                    FIRST_FREQ <= freq_q;
                    FIRST_REVERSE <= pct_q[15];
                    FIRST_DONE <= 1'b1;
                end
                state_q <= ST_IDLE;
            end
            default: begin
                state_q <= ST_IDLE;
            end
        endcase
    end
end

endmodule

/* File: shared/curve_regs.vh */
// register map, reset values and constants of the three-point curve mapper
// assumes a 16-bit register port addressed by parameter number
`ifndef CURVE_MAP_REGS_VH
`define CURVE_MAP_REGS_VH

// register addresses
`define ADDR_POS_LO_X 16'h033F
`define ADDR_POS_LO_P 16'h0340
`define ADDR_POS_MID_X 16'h0341
`define ADDR_POS_MID_P 16'h0342
`define ADDR_POS_HI_X 16'h0343
`define ADDR_POS_HI_P 16'h0344
`define ADDR_NEG_NZ_X 16'h0345
`define ADDR_NEG_NZ_P 16'h0346
`define ADDR_NEG_MID_X 16'h0347
`define ADDR_NEG_MID_P 16'h0348
`define ADDR_NEG_FAR_X 16'h0349
`define ADDR_NEG_FAR_P 16'h034A
`define ADDR_SEC_LO_X 16'h0339
`define ADDR_SEC_LO_P 16'h033A
`define ADDR_SEC_MID_X 16'h033B
`define ADDR_SEC_MID_P 16'h033C
`define ADDR_SEC_HI_X 16'h033D
`define ADDR_SEC_HI_P 16'h033E
`define ADDR_CURVE_SEL 16'h0332
`define ADDR_RANGE_SEL 16'h031C
`define ADDR_MAX_FREQ 16'h0100
`define ADDR_FIRST_RESULT 16'h0400
`define ADDR_SECOND_RESULT 16'h0401
`define ADDR_STATUS 16'h0402

// storage indices
`define IDX_POS_LO_X 5'h00
`define IDX_POS_LO_P 5'h01
`define IDX_POS_MID_X 5'h02
`define IDX_POS_MID_P 5'h03
`define IDX_POS_HI_X 5'h04
`define IDX_POS_HI_P 5'h05
`define IDX_NEG_NZ_X 5'h06
`define IDX_NEG_NZ_P 5'h07
`define IDX_NEG_MID_X 5'h08
`define IDX_NEG_MID_P 5'h09
`define IDX_NEG_FAR_X 5'h0A
`define IDX_NEG_FAR_P 5'h0B
`define IDX_SEC_LO_X 5'h0C
`define IDX_SEC_LO_P 5'h0D
`define IDX_SEC_MID_X 5'h0E
`define IDX_SEC_MID_P 5'h0F
`define IDX_SEC_HI_X 5'h10
`define IDX_SEC_HI_P 5'h11
`define IDX_CURVE_SEL 5'h12
`define IDX_RANGE_SEL 5'h13
`define IDX_MAX_FREQ 5'h14
`define IDX_NONE 5'h1F
`define NUM_REGS 21

// reset values, hundredths of a volt, milliamp or percent
`define RST_POS_LO_X 16'h0000
`define RST_POS_LO_P 16'h0000
`define RST_POS_MID_X 16'h01F4
`define RST_POS_MID_P 16'h1388
`define RST_POS_HI_X 16'h03E8
`define RST_POS_HI_P 16'h2710
`define RST_NEG_NZ_X 16'h0000
`define RST_NEG_NZ_P 16'h0000
`define RST_NEG_MID_X 16'hFE0C
`define RST_NEG_MID_P 16'hEC78
`define RST_NEG_FAR_X 16'hFC18
`define RST_NEG_FAR_P 16'hD8F0
`define RST_SEC_LO_X 16'h0190
`define RST_SEC_LO_P 16'h0000
`define RST_SEC_MID_X 16'h04B0
`define RST_SEC_MID_P 16'h1388
`define RST_SEC_HI_X 16'h07D0
`define RST_SEC_HI_P 16'h2710
`define RST_CURVE_SEL 16'h0000
`define RST_RANGE_SEL 16'h0000
`define RST_MAX_FREQ 16'h1770

// mode encodings
`define CURVE_NORMAL  2'h0
`define CURVE_FIRST   2'h1
`define CURVE_SECOND  2'h2
`define CURVE_BOTH    2'h3
`define RANGE_BIPOLAR 16'h0003

// arithmetic
`define PCT_FULL_SCALE 17'h02710
`define DIV_STEPS      6'h20

`endif

/* File: rtl/curve_divider.v */
// unsigned restoring divider, one quotient bit per clock
// assumes the caller holds off a new start until done has pulsed
module curve_divider (
    input wire clk,
    input wire rst,
    input wire start,
    input wire [31:0] dividend,
    input wire [16:0] divisor,
    output reg [31:0] quotient,
    output reg done
);
`include "curve_regs.vh"

reg [31:0] num_q;
reg [16:0] den_q;
reg [17:0] rem_q;
reg [5:0] cnt_q;
reg run_q;
wire [17:0] rem_shift = {rem_q[16:0], num_q[31]};
wire fits = rem_shift >= {1'b0, den_q};
wire [17:0] rem_sub = rem_shift - {1'b0, den_q};

////////////////////////////////////////////////////////////////////////////////
always @(posedge clk) begin
    if (rst) begin
        num_q <= 32'h00000000;
        den_q <= 17'h00000;
        rem_q <= 18'h00000;
        cnt_q <= 6'h00;
        run_q <= 1'b0;
        quotient <= 32'h00000000;
        done <= 1'b0;
    end else begin
        done <= 1'b0;
        if (start) begin
            num_q <= dividend;
            den_q <= divisor;
            rem_q <= 18'h00000;
            cnt_q <= `DIV_STEPS;
            run_q <= 1'b1;
        end else if (run_q) begin
            // quotient bits shift into the vacated low end of the dividend
            num_q <= {num_q[30:0], fits};
            rem_q <= fits ? rem_sub : rem_shift;
            cnt_q <= cnt_q - 6'h01;
            if (cnt_q == 6'h01) begin
                run_q <= 1'b0;
                done <= 1'b1;
                quotient <= {num_q[30:0], fits};
            end
        end
    end
end

endmodule

/* File: sim/curve_map_properties.sv */
// port assertions of the curve mapper
// assumes a bind onto curve_map; sees its ports only
module curve_map_properties (
    input logic CLK, SYS_RST, WR, RD, FIRST_VALID, SECOND_VALID, FIRST_REVERSE, FIRST_DONE,
    input logic FIRST_CURVE_ON, SECOND_REVERSE, SECOND_DONE, SECOND_CURVE_ON,
    input logic [15:0] ADDR, WDATA, RDATA, FIRST_PERCENT, FIRST_FREQ, SECOND_PERCENT
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);
    ////////////////////////////////////////////////////////////
    a_read_window: assert property (RDATA != 16'h0000 |-> $past(RD))
        else $error("read data outside its cycle");
    // second input may queue behind the first, hence the longer bound
    a_first_answer: assert property (FIRST_VALID |-> ##[1:200] FIRST_DONE)
        else $error("first result missing");
    a_second_answer: assert property (SECOND_VALID |-> ##[1:300] SECOND_DONE)
        else $error("second result missing");
    a_fwd_sign: assert property (FIRST_DONE |-> FIRST_REVERSE == FIRST_PERCENT[15])
        else $error("direction disagrees with sign");
    a_zero_cmd: assert property (FIRST_DONE && FIRST_PERCENT == 16'h0000 |->
        FIRST_FREQ == 16'h0000) else $error("zero percent not zero speed");
    a_curve_off: assert property (FIRST_DONE && !FIRST_CURVE_ON |->
        FIRST_PERCENT == 16'h0000) else $error("first curve off yet output");
    a_second_off: assert property (SECOND_DONE && !SECOND_CURVE_ON |->
        SECOND_PERCENT == 16'h0000 && !SECOND_REVERSE) else $error("second curve off yet output");
    a_select_path: assert property (WR && ADDR == 16'h0332 |-> ##2
        {14'h0000, SECOND_CURVE_ON, FIRST_CURVE_ON} == ($past(WDATA, 2) & 16'h0003))
        else $error("curve enables do not follow select");
    c_reverse: cover property (FIRST_DONE && FIRST_REVERSE);
    c_both: cover property (FIRST_VALID && SECOND_VALID);
    c_second: cover property (SECOND_DONE && SECOND_PERCENT != 16'h0000);
endmodule

/* File: sim/src_model.sv */
// sampling converter and frequency reference model facing the curve mapper
// assumes samples are handed over after a rising edge with one-cycle valids
module src_model (
    input logic clk, first_done, first_reverse, second_done, second_reverse,
    input logic [15:0] first_percent, first_freq, second_percent, second_freq,
    output logic [15:0] first_sample = 16'h0000, second_sample = 16'h0000,
    output logic first_valid = 1'b0, second_valid = 1'b0
);
    logic [15:0] pct1, frq1, pct2, frq2;
    logic rev1, rev2;
    task automatic send(input logic [1:0] sel, input logic [15:0] a, b, output logic ok);
        logic g1, g2;
        g1 = !sel[0];
        g2 = !sel[1];
        @(posedge clk);
        first_sample <= a;
        second_sample <= b;
        first_valid <= sel[0];
        second_valid <= sel[1];
        @(posedge clk);
        first_valid <= 1'b0;
        second_valid <= 1'b0;
        // released lines carry no stale value
        first_sample <= ~a;
        second_sample <= ~b;
        for (int n = 0; n < 300 && !(g1 && g2); n++) begin
            @(negedge clk);
            if (first_done) begin
                g1 = 1'b1;
                pct1 = first_percent;
                frq1 = first_freq;
                rev1 = first_reverse;
            end
            if (second_done) begin
                g2 = 1'b1;
                pct2 = second_percent;
                frq2 = second_freq;
                rev2 = second_reverse;
            end
        end
        ok = g1 && g2;
    endtask
endmodule

/* File: sim/test_analog_input_three_point_curve.sv */
`include "curve_regs.vh"
// self-checking bench of the curve mapper
// assumes the design, shared header, source model and checker are compiled first
module test_analog_input_three_point_curve;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata, f_smp, s_smp, f_pct, f_frq, s_pct, s_frq;
    logic f_vld, s_vld, f_rev, s_rev, f_done, s_done, f_on, s_on, busy;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #12.5 clk = ~clk;
    curve_map curve_map_inst (.CLK(clk), .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .FIRST_SAMPLE(f_smp), .FIRST_VALID(f_vld),
        .SECOND_SAMPLE(s_smp), .SECOND_VALID(s_vld), .FIRST_PERCENT(f_pct),
        .FIRST_FREQ(f_frq), .FIRST_REVERSE(f_rev), .FIRST_DONE(f_done), .FIRST_CURVE_ON(f_on),
        .SECOND_PERCENT(s_pct), .SECOND_FREQ(s_frq), .SECOND_REVERSE(s_rev),
        .SECOND_DONE(s_done), .SECOND_CURVE_ON(s_on), .BUSY(busy));
    src_model src_model_inst (.clk(clk), .first_sample(f_smp), .first_valid(f_vld),
        .second_sample(s_smp), .second_valid(s_vld), .first_done(f_done),
        .first_percent(f_pct), .first_freq(f_frq), .first_reverse(f_rev),
        .second_done(s_done), .second_percent(s_pct), .second_freq(s_frq),
        .second_reverse(s_rev));
    ////////////////////////////////////////////////////////////
    task automatic close_out;
        if (failures == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // all scenarios need fewer than two thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            failures = failures + 1;
            close_out();
        end
    end
    task automatic check(input logic [15:0] seen, exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t %s: %h not %h", $time, what, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [15:0] a, d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [15:0] a, exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check(rdata, exp, "register read");
    endtask
    task automatic check_out(input logic [15:0] pct, frq, input logic rev, input logic [15:0] e);
        int m;
        m = e[15] ? -int'($signed(e)) : int'($signed(e));
        check(pct, e, "percent");
        check(frq, 16'(m * int'(`RST_MAX_FREQ) / 10000), "frequency");
        check({15'h0000, rev}, {15'h0000, e[15]}, "direction");
    endtask
    task automatic run(input logic [1:0] sel, input logic [15:0] x1, x2, p1, p2);
        logic ok;
        src_model_inst.send(sel, x1, x2, ok);
        check({15'h0000, ok}, 16'h0001, "result missing");
        if (sel[0]) check_out(src_model_inst.pct1, src_model_inst.frq1, src_model_inst.rev1, p1);
        if (sel[1]) check_out(src_model_inst.pct2, src_model_inst.frq2, src_model_inst.rev2, p2);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [15:0] rv [12] = '{`RST_POS_LO_X, `RST_POS_LO_P, `RST_POS_MID_X, `RST_POS_MID_P,
            `RST_POS_HI_X, `RST_POS_HI_P, `RST_NEG_NZ_X, `RST_NEG_NZ_P, `RST_NEG_MID_X,
            `RST_NEG_MID_P, `RST_NEG_FAR_X, `RST_NEG_FAR_P};
        for (int i = 0; i < 12; i++) begin
            logic [15:0] a;
            a = `ADDR_POS_LO_X + 16'(i);
            reg_rd(a, rv[i]);
            reg_wr(a, 16'h8001 + 16'(i));
            reg_rd(a, 16'h8001 + 16'(i));
            reg_wr(a, rv[i]);
        end
        reg_rd(16'h0350, 16'h0000);
        reg_wr(`ADDR_FIRST_RESULT, 16'hFFFF);
        reg_rd(`ADDR_FIRST_RESULT, 16'h0000);
    endtask
    task automatic t_pos;
        logic [15:0] xs [6] = '{16'h0032, 16'h0064, 16'h0065, 16'h012C, 16'h03E8, 16'h04B0};
        logic [15:0] ps [6] = '{16'h0000, 16'h0000, 16'h03F2, 16'h0BB8, 16'h2710, 16'h2710};
        reg_wr(`ADDR_CURVE_SEL, 16'h0001);
        reg_wr(`ADDR_POS_LO_X, 16'h0064);
        reg_wr(`ADDR_POS_LO_P, 16'h03E8);
        for (int i = 0; i < 6; i++) run(2'b01, xs[i], 16'h0000, ps[i], 16'h0000);
        reg_rd(`ADDR_FIRST_RESULT, 16'h2710);
        reg_wr(`ADDR_POS_HI_P, 16'h07D0);
        run(2'b01, 16'h02EE, 16'h0000, 16'h0DAC, 16'h0000);
        reg_wr(`ADDR_POS_HI_P, 16'h2710);
    endtask
    task automatic t_neg;
        logic [15:0] xs [7] = '{16'hFFCE, 16'hFF9C, 16'hFF92, 16'hFF9C, 16'hFC18, 16'hFB50,
            16'h03E8};
        logic [15:0] ps [7] = '{16'h0000, 16'h0000, 16'hFBB4, 16'h0000, 16'hD8F0, 16'hD8F0,
            16'h2710};
        reg_wr(`ADDR_RANGE_SEL, `RANGE_BIPOLAR);
        reg_wr(`ADDR_NEG_NZ_X, 16'hFF9C);
        reg_wr(`ADDR_NEG_NZ_P, 16'hFC18);
        for (int i = 0; i < 7; i++) run(2'b01, xs[i], 16'h0000, ps[i], 16'h0000);
        reg_wr(`ADDR_RANGE_SEL, 16'h0000);
        run(2'b01, 16'hFED4, 16'h0000, 16'h0000, 16'h0000);
    endtask
    task automatic t_second;
        for (int s = 0; s < 4; s++) begin
            reg_wr(`ADDR_CURVE_SEL, 16'(s));
            @(posedge clk);
            @(negedge clk);
            check({14'h0000, s_on, f_on}, 16'(s), "curve enable");
        end
        reg_wr(`ADDR_SEC_LO_X, 16'h00C8);
        reg_wr(`ADDR_SEC_LO_P, 16'h03E8);
        run(2'b11, 16'h03E8, 16'h00C8, 16'h2710, 16'h0000);
        run(2'b11, 16'h0000, 16'h00C9, 16'h0000, 16'h03EC);
        reg_rd(`ADDR_SECOND_RESULT, 16'h03EC);
        reg_wr(`ADDR_CURVE_SEL, 16'h0002);
        run(2'b11, 16'h03E8, 16'h07D0, 16'h0000, 16'h2710);
        reg_wr(`ADDR_CURVE_SEL, 16'h0000);
        run(2'b11, 16'h03E8, 16'h07D0, 16'h0000, 16'h0000);
        reg_rd(`ADDR_STATUS, 16'h0000);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs();
        t_pos();
        t_neg();
        t_second();
        close_out();
    end
endmodule
bind curve_map curve_map_properties curve_map_properties_inst (.CLK(CLK), .SYS_RST(SYS_RST),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .FIRST_VALID(FIRST_VALID),
    .SECOND_VALID(SECOND_VALID), .FIRST_PERCENT(FIRST_PERCENT), .FIRST_FREQ(FIRST_FREQ),
    .FIRST_REVERSE(FIRST_REVERSE), .FIRST_DONE(FIRST_DONE), .FIRST_CURVE_ON(FIRST_CURVE_ON),
    .SECOND_PERCENT(SECOND_PERCENT), .SECOND_REVERSE(SECOND_REVERSE),
    .SECOND_DONE(SECOND_DONE), .SECOND_CURVE_ON(SECOND_CURVE_ON));
